// [common/relay_coil_pkg.sv]
// Constants and types shared by the relay coil operand bank.
// Assumes a 10 MHz core clock and a word-indexed register port.
package relay_coil_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // Register indices on the plain register port.
  localparam logic [5:0] A_CTRL    = 6'h00;
  localparam logic [5:0] A_CFG     = 6'h01;
  localparam logic [5:0] A_STATUS  = 6'h02;
  localparam logic [5:0] A_IN_IMG  = 6'h03;
  localparam logic [5:0] A_OUT     = 6'h04;
  localparam logic [5:0] A_MBANK   = 6'h08;
  localparam logic [5:0] A_NBANK   = 6'h0C;
  localparam logic [5:0] A_T_STAT  = 6'h10;
  localparam logic [5:0] A_T_PRE   = 6'h11;
  localparam logic [5:0] A_T_UPD   = 6'h12;
  localparam logic [5:0] A_C_STAT  = 6'h13;
  localparam logic [5:0] A_C_PRE   = 6'h14;
  localparam logic [5:0] A_C_UPD   = 6'h15;
  localparam logic [5:0] A_C_LAST  = 6'h16;
  localparam logic [5:0] A_J_LO    = 6'h18;
  localparam logic [5:0] A_J_HI    = 6'h19;
  localparam logic [5:0] A_K_LO    = 6'h1A;
  localparam logic [5:0] A_K_HI    = 6'h1B;
  localparam logic [5:0] A_EDGE_IN = 6'h1C;
  localparam logic [5:0] A_EDGE_RS = 6'h1D;
  localparam logic [5:0] A_EDGE_FL = 6'h1E;

  // Field positions.
  localparam int unsigned CTRL_SCAN_BIT = 0;
  localparam int unsigned UPD_IDX_LSB   = 16;
  localparam int unsigned KEEP_BIT      = 16;

  // Bank sizes.
  localparam int unsigned N_DIN   = 12;
  localparam int unsigned N_KEY   = 4;
  localparam int unsigned N_DOUT  = 8;
  localparam int unsigned N_AUX   = 127;
  localparam int unsigned N_TMR   = 31;
  localparam int unsigned N_NET   = 63;
  localparam int unsigned N_EDGE  = 32;
  localparam int unsigned N_ANA   = 4;

  // Special flag positions inside the retained bank (coil number minus one).
  localparam int unsigned F_FIRST  = 48;
  localparam int unsigned F_BLINK  = 49;
  localparam int unsigned F_SEASON = 50;
  localparam int unsigned F_TEMP0  = 51;
  localparam int unsigned F_SER_RX = 55;
  localparam int unsigned F_NET_RX = 56;
  localparam int unsigned F_FDIR   = 57;
  localparam int unsigned F_EMAIL  = 59;
  localparam int unsigned F_FB_DN  = 60;
  localparam int unsigned F_FB_ER  = 61;
  localparam int unsigned F_FB_TO  = 62;

  // Input variant field codes, input masks and output masks.
  localparam logic [1:0]  VAR_IN6   = 2'h0;
  localparam logic [1:0]  VAR_IN8   = 2'h1;
  localparam logic [1:0]  VAR_IN12  = 2'h2;
  localparam logic [11:0] MASK_IN6  = 12'h03F;
  localparam logic [11:0] MASK_IN8  = 12'h0FF;
  localparam logic [11:0] MASK_IN12 = 12'hFFF;
  localparam logic [7:0]  MASK_OUT4 = 8'h0F;
  localparam logic [7:0]  MASK_OUT8 = 8'hFF;

  // Timing.
  localparam int unsigned CLK_KHZ        = 10_000;
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam logic [1:0]  PU_SYNC_CYC    = 2'h2;

  typedef struct packed {
    logic       keypad;
    logic       out8;
    logic [1:0] in_var;
  } cfg_s;

  localparam cfg_s CFG_RST = '{keypad: 1'b1, out8: 1'b1, in_var: VAR_IN12};

  typedef struct packed {
    logic        clr;
    logic        down;
    logic [4:0]  idx;
    logic [15:0] cur;
  } cnt_upd_s;

  typedef enum logic [1:0] {PU_WAIT, PU_CLEAR, PU_RUN} pu_e;

endpackage : relay_coil_pkg

// [sim/relay_coil_chk.sv]
// Assertion checker for the relay coil operand bank, bound to its top module.
// Assumes the plain register port and the scan-end command of the bank.
module relay_coil_chk
  import relay_coil_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rdata,
  // Outputs
  input wire logic [N_DOUT-1:0] dout,
  input wire logic [N_ANA-1:0]  analog_sel,
  input wire logic              email_send,
  input wire logic [N_NET-1:0]  net_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic scan_q;
  logic out8_q;
  wire  scan_w = wr_en && addr == A_CTRL && wdata[CTRL_SCAN_BIT];
  wire  cfg_w  = wr_en && addr == A_CFG;

  // The output width is tracked here because the bank never shows it on a pin.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_q <= 1'b0;
      out8_q <= 1'b1;
    end else begin
      scan_q <= scan_w;
      if (cfg_w) begin
        out8_q <= wdata[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_wide;
    cfg_w && wdata[1:0] == VAR_IN12;
  endsequence
  sequence s_cfg_narrow;
    cfg_w && wdata[1:0] != VAR_IN12;
  endsequence

  a_rdata_idle: assert property (!rd_en |=> rdata == '0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (rd_en && addr == 6'h3F |=> rdata == '0)
    else $error("unmapped read returned data");
  a_dout_scan_only: assert property (!scan_q |-> $stable(dout))
    else $error("digital outputs moved between scan ends");
  a_net_scan_only: assert property (!scan_q |-> $stable(net_out))
    else $error("network outputs moved between scan ends");
  a_email_cause: assert property (email_send |-> scan_q)
    else $error("mail request without a scan end");
  a_email_single: assert property (email_send |=> !email_send)
    else $error("mail request longer than one cycle");
  a_analog_wide: assert property (s_cfg_wide |=> ##[0:1] analog_sel == 4'hF)
    else $error("analog channels not selected for twelve inputs");
  a_analog_narrow: assert property (s_cfg_narrow |=> ##[0:1] analog_sel == 4'h0)
    else $error("analog channels selected on a narrow variant");
  a_dout_four: assert property (scan_q && !out8_q |-> dout[7:4] == 4'h0)
    else $error("upper outputs driven on a four-output variant");
endmodule : relay_coil_chk

bind relay_coil_operand_bank relay_coil_chk #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) chk_u (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .dout(dout), .analog_sel(analog_sel),
  .email_send(email_send), .net_out(net_out)
);

// [sim/relay_coil_operand_bank_tb_top.sv]
// Self-checking bench for the relay coil operand bank.
// Assumes the checker is bound by its own file and the field model drives the pins.
module relay_coil_operand_bank_tb_top import relay_coil_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] W_FLAG  = A_MBANK + 6'h01;
  localparam logic [5:0] W_MTOP  = A_MBANK + 6'h03;
  localparam logic [5:0] W_NFLAG = A_NBANK + 6'h01;

  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd_q;
  logic [11:0]       din;
  logic [3:0]        key_in, temp_err, analog_sel;
  logic [7:0]        dout;
  logic [62:0]       net_in, net_out;
  logic              keep_en, fast_dir, summer_evt, winter_evt, serial_rx, network_rx;
  logic              fb_done, fb_error, fb_timeout, net_in_valid, email_send, email_q;
  int                errors = 0;
  int                compares = 0;

  always #50 clk = ~clk;

  relay_coil_operand_bank #(.BLINK_HALF_CYCLES(4)) dut_u (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .din(din), .key_in(key_in), .keep_en(keep_en), .dout(dout),
    .analog_sel(analog_sel), .summer_evt(summer_evt), .winter_evt(winter_evt),
    .temp_err(temp_err), .fast_dir(fast_dir), .serial_rx(serial_rx), .network_rx(network_rx),
    .fb_done(fb_done), .fb_error(fb_error), .fb_timeout(fb_timeout),
    .email_send(email_send), .net_in(net_in), .net_in_valid(net_in_valid), .net_out(net_out));

  relay_field_model field_u (
    .clk(clk), .din(din), .key_in(key_in), .keep_en(keep_en), .temp_err(temp_err),
    .fast_dir(fast_dir), .summer_evt(summer_evt), .winter_evt(winter_evt),
    .serial_rx(serial_rx), .network_rx(network_rx), .fb_done(fb_done), .fb_error(fb_error),
    .fb_timeout(fb_timeout), .net_in(net_in), .net_in_valid(net_in_valid));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A spare cycle follows every strobe so no strobe is driven twice in one step.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 email_q = email_send;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_q = rdata;
    @(posedge clk);
  endtask : rd

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(64'(rd_q), 64'(e));
  endtask : rdc

  task automatic rdb(input logic [5:0] a, input int b, input logic e);
    rd(a);
    chk(64'(rd_q[b]), 64'(e));
  endtask : rdb

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_first();
    rdc(A_CFG, 32'h0000_000E);
    chk(64'(analog_sel), 64'hF);
    rdc(6'h3F, 32'h0);
    rdb(W_FLAG, F_FIRST - 32, 1'b1);
    wr(A_CTRL, 32'h1);
    rdb(W_FLAG, F_FIRST - 32, 1'b0);
  endtask : t_first

  task automatic t_edges();
    wr(A_EDGE_IN, 32'h3);
    rdc(A_EDGE_RS, 32'h3);
    wr(A_CTRL, 32'h1);
    wr(A_EDGE_IN, 32'h1);
    rdc(A_EDGE_RS, 32'h0);
    rdc(A_EDGE_FL, 32'h2);
    wr(A_CTRL, 32'h1);
    rdc(A_EDGE_FL, 32'h0);
  endtask : t_edges

  task automatic t_outputs();
    wr(A_OUT, 32'h0000_00A5);
    chk(64'(dout), 64'h0);
    wr(A_CTRL, 32'h1);
    chk(64'(dout), 64'hA5);
    wr(A_CFG, 32'h0000_000A);
    wr(A_CTRL, 32'h1);
    chk(64'(dout), 64'(8'hA5 & MASK_OUT4));
  endtask : t_outputs

  task automatic t_inputs();
    logic [11:0] m [3] = '{MASK_IN6, MASK_IN8, MASK_IN12};
    field_u.set_levels(12'hABC, 4'h0, 1'b0);
    for (int v = 0; v < 3; v++) begin
      wr(A_CFG, 32'(v) | 32'h4);
      wr(A_CTRL, 32'h1);
      chk(64'(analog_sel), (v == 2) ? 64'hF : 64'h0);
      rdc(A_IN_IMG, 32'(12'hABC & m[v]) | ((v == 2) ? 32'h000F_0000 : 32'h0));
    end
    wr(A_CFG, 32'h0000_000E);
    wr(A_CTRL, 32'h1);
    field_u.set_levels(12'h000, 4'h0, 1'b0);
    rd(A_IN_IMG);
    chk(64'(rd_q[11:0]), 64'hABC);
    chk(64'(rd_q[19:12]), 64'hF5);
  endtask : t_inputs

  task automatic t_flags();
    int b [7] = '{F_SEASON, F_SEASON, F_SER_RX, F_NET_RX, F_FB_DN, F_FB_ER, F_FB_TO};
    for (int k = 0; k < 7; k++) begin
      field_u.pulse(k);
      repeat (2) @(posedge clk);
      rdb(W_FLAG, b[k] - 32, k != 1);
    end
    field_u.set_levels(12'h000, 4'h1, 1'b0);
    repeat (4) @(posedge clk);
    rdb(W_FLAG, F_TEMP0 - 32, 1'b1);
    wr(W_NFLAG, 32'h0);
    rdc(W_NFLAG, 32'h0);
  endtask : t_flags

  task automatic t_email();
    for (int r = 0; r < 2; r++) begin
      wr(W_FLAG, 32'h1 << (F_EMAIL - 32));
      wr(A_CTRL, 32'h1);
      chk(64'(email_q), 64'h1);
      wr(A_CTRL, 32'h1);
      chk(64'(email_q), 64'h0);
      wr(W_FLAG, 32'h0);
      wr(A_CTRL, 32'h1);
    end
  endtask : t_email

  // Reads are two cycles apart, so a four-cycle half period inverts every second sample.
  task automatic t_blink();
    logic s [12];
    for (int i = 0; i < 12; i++) begin
      rd(W_FLAG);
      s[i] = rd_q[F_BLINK - 32];
    end
    for (int i = 2; i < 12; i++) begin
      chk(64'(s[i] ^ s[i-2]), 64'h1);
    end
  endtask : t_blink

  task automatic t_timer();
    wr(A_T_PRE, 32'h5);
    for (int c = 4; c < 7; c++) begin
      wr(A_T_UPD, 32'h0003_0000 | 32'(c));
      rdc(A_T_STAT, (c >= 5) ? 32'h8 : 32'h0);
    end
    wr(A_T_UPD, 32'h001F_0009);
    rdc(A_T_STAT, 32'h8);
  endtask : t_timer

  task automatic t_counter();
    int         cv [7] = '{1, 2, 1, 1, 0, 3, 3};
    logic [1:0] md [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
    logic       coil = 1'b0;
    cnt_upd_s   u;
    wr(A_C_PRE, 32'h2);
    for (int i = 0; i < 7; i++) begin
      u = '{clr: md[i][1], down: md[i][0], idx: 5'h0, cur: 16'(cv[i])};
      wr(A_C_UPD, 32'(u));
      if (u.clr || (u.down && u.cur == 16'h0)) coil = 1'b0;
      else if (!u.down && u.cur >= 16'h2) coil = 1'b1;
      rdb(A_C_STAT, 0, coil);
      rdc(A_C_LAST, u.clr ? 32'h0 : 32'(u.cur));
    end
  endtask : t_counter

  task automatic t_net();
    field_u.send_net(63'h1234_5678_9ABC_DEF0, 1'b1);
    @(posedge clk);
    wr(A_CTRL, 32'h1);
    field_u.send_net(63'h0, 1'b0);
    wr(A_CTRL, 32'h1);
    wr(A_J_LO, 32'h0);
    rdc(A_J_LO, 32'h9ABC_DEF0);
    rdc(A_J_HI, 32'h1234_5678);
    wr(A_K_LO, 32'hA5A5_0F0F);
    wr(A_K_HI, 32'hFFFF_FFFF);
    chk(64'(net_out), 64'h0);
    wr(A_CTRL, 32'h1);
    chk(64'(net_out), 64'h7FFF_FFFF_A5A5_0F0F);
  endtask : t_net

  task automatic t_banks();
    wr(W_MTOP, 32'hFFFF_FFFF);
    rdc(W_MTOP, 32'h7FFF_FFFF);
    wr(A_MBANK, 32'h1234_5678);
    wr(A_NBANK, 32'h0000_ABCD);
    rdc(A_NBANK, 32'h0000_ABCD);
    for (int k = 1; k >= 0; k--) begin
      field_u.set_levels(12'h000, 4'h0, k[0]);
      do_reset();
      rdc(A_MBANK, k[0] ? 32'h1234_5678 : 32'h0);
      rdc(A_NBANK, 32'h0);
    end
  endtask : t_banks

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    do_reset();
    t_first();
    t_edges();
    t_outputs();
    t_inputs();
    t_flags();
    t_email();
    t_blink();
    t_timer();
    t_counter();
    t_net();
    t_banks();
    report_and_stop();
  end

  // The whole sequence needs well under a thousand cycles; this bound cuts a hang.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule : relay_coil_operand_bank_tb_top

// [sim/relay_field_model.sv]
// Field side model: switches, sensors, strap, event lines and a remote station.
// Assumes its tasks are called just after a rising clock edge.
module relay_field_model (
  // Clock
  input  wire logic clk,
  // Field levels
  output logic [11:0] din,
  output logic [3:0]  key_in,
  output logic        keep_en,
  output logic [3:0]  temp_err,
  output logic        fast_dir,
  // Event lines
  output logic        summer_evt,
  output logic        winter_evt,
  output logic        serial_rx,
  output logic        network_rx,
  output logic        fb_done,
  output logic        fb_error,
  output logic        fb_timeout,
  // Remote station
  output logic [62:0] net_in,
  output logic        net_in_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] ev;
  assign {fb_timeout, fb_error, fb_done, network_rx, serial_rx, winter_evt, summer_evt} = ev;

  initial begin
    {din, key_in, keep_en, temp_err, fast_dir, ev, net_in_valid} = '0;
    net_in = '0;
  end

  // An idle station shows a moving pattern, so a stale word is never mistaken for data.
  // It moves on the falling edge so it never meets a task's drive in one time step.
  always @(negedge clk) begin
    if (!net_in_valid) begin
      net_in <= ~net_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_levels(input logic [11:0] d, input logic [3:0] t, input logic kp);
    din      <= d;
    key_in   <= 4'h5;
    temp_err <= t;
    keep_en  <= kp;
  endtask : set_levels

  // Events stay high two cycles and low two cycles so the synchroniser sees them.
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    repeat (2) @(posedge clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic send_net(input logic [62:0] w, input logic v);
    net_in       <= w;
    net_in_valid <= v;
  endtask : send_net
endmodule : relay_field_model

// [src/relay_coil_operand_bank.sv]
// Per-scan operand and coil bank of a programmable relay.
// Assumes the user program drives the register port on clk and writes the
// scan-end command once per program scan; field pins are asynchronous.

module relay_coil_operand_bank
  import relay_coil_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [DATA_W-1:0]   rdata,
  // Field pins
  input  wire logic [N_DIN-1:0]    din,
  input  wire logic [N_KEY-1:0]    key_in,
  input  wire logic                keep_en,
  output logic      [N_DOUT-1:0]   dout,
  output logic      [N_ANA-1:0]    analog_sel,
  // System events and levels
  input  wire logic                summer_evt,
  input  wire logic                winter_evt,
  input  wire logic [3:0]          temp_err,
  input  wire logic                fast_dir,
  input  wire logic                serial_rx,
  input  wire logic                network_rx,
  input  wire logic                fb_done,
  input  wire logic                fb_error,
  input  wire logic                fb_timeout,
  output logic                     email_send,
  // Remote station link
  input  wire logic [N_NET-1:0]    net_in,
  input  wire logic                net_in_valid,
  output logic      [N_NET-1:0]    net_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The third stage only feeds event edge detection.

  localparam int unsigned N_EVT  = 7;
  localparam int unsigned SYNC_W = N_DIN + N_KEY + 1 + 4 + 1 + N_EVT;

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [N_EVT-1:0]  s3_q;
  logic [SYNC_W-1:0] sync_in;

  assign sync_in = {din, key_in, keep_en, temp_err, fast_dir, summer_evt, winter_evt,
                    serial_rx, network_rx, fb_done, fb_error, fb_timeout};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q[N_EVT-1:0];
    end
  end

  logic [N_DIN-1:0] din_s;
  logic [N_KEY-1:0] key_s;
  logic             keep_s;
  logic [3:0]       terr_s;
  logic             fdir_s;
  logic [N_EVT-1:0] evt;

  assign din_s  = s2_q[SYNC_W-1 -: N_DIN];
  assign key_s  = s2_q[SYNC_W-N_DIN-1 -: N_KEY];
  assign keep_s = s2_q[N_EVT+5];
  assign terr_s = s2_q[N_EVT+4 -: 4];
  assign fdir_s = s2_q[N_EVT];
  assign evt    = s2_q[N_EVT-1:0] & ~s3_q;

  logic ev_summer, ev_winter, ev_ser, ev_net, ev_dn, ev_er, ev_to;
  assign {ev_summer, ev_winter, ev_ser, ev_net, ev_dn, ev_er, ev_to} = evt;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.

  logic scan_end, wr_cfg, wr_out, wr_m, wr_n, wr_tpre, wr_tupd;
  logic wr_cpre, wr_cupd, wr_klo, wr_khi, wr_edge;

  assign scan_end = wr_en && (addr == A_CTRL) && wdata[CTRL_SCAN_BIT];
  assign wr_cfg   = wr_en && (addr == A_CFG);
  assign wr_out   = wr_en && (addr == A_OUT);
  assign wr_m     = wr_en && (addr[5:2] == A_MBANK[5:2]);
  assign wr_n     = wr_en && (addr[5:2] == A_NBANK[5:2]);
  assign wr_tpre  = wr_en && (addr == A_T_PRE);
  assign wr_tupd  = wr_en && (addr == A_T_UPD);
  assign wr_cpre  = wr_en && (addr == A_C_PRE);
  assign wr_cupd  = wr_en && (addr == A_C_UPD);
  assign wr_klo   = wr_en && (addr == A_K_LO);
  assign wr_khi   = wr_en && (addr == A_K_HI);
  assign wr_edge  = wr_en && (addr == A_EDGE_IN);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, power-up sequence and scan bookkeeping.

  cfg_s        cfg_q;
  pu_e         pu_q;
  logic [1:0]  pu_cnt_q;
  logic        keep_q;
  logic        first_q;
  logic [15:0] scan_cnt_q;

  // The keep strap is only trusted once it has crossed the synchroniser.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_q     <= PU_WAIT;
      pu_cnt_q <= '0;
      keep_q   <= 1'b0;
    end else begin
      unique case (pu_q)
        PU_WAIT: begin
          pu_cnt_q <= pu_cnt_q + 2'h1;
          if (pu_cnt_q == PU_SYNC_CYC) begin
            keep_q <= keep_s;
            pu_q   <= keep_s ? PU_RUN : PU_CLEAR;
          end
        end
        PU_CLEAR: pu_q <= PU_RUN;
        PU_RUN:   pu_q <= PU_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q      <= CFG_RST;
      first_q    <= 1'b1;
      scan_cnt_q <= '0;
    end else begin
      if (wr_cfg) cfg_q <= cfg_s'(wdata[3:0]);
      if (scan_end) first_q <= 1'b0;
      if (scan_end) scan_cnt_q <= scan_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink generator.

  logic [31:0] blink_cnt_q;
  logic        blink_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_q <= '0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary banks. Hardware sets are applied after software writes so that
  // an event landing on a clear is kept.

  logic [N_AUX-1:0] m_q, m_d;
  logic [N_AUX-1:0] n_q, n_d;

  always_comb begin
    m_d = m_q;
    n_d = n_q;
    if (pu_q == PU_CLEAR) m_d = '0;
    for (int b = 0; b < N_AUX; b++) begin
      if (wr_m && (2'(b / 32) == addr[1:0])) m_d[b] = wdata[b % 32];
      if (wr_n && (2'(b / 32) == addr[1:0])) n_d[b] = wdata[b % 32];
    end
    if (pu_q == PU_RUN && first_q) m_d[F_FIRST] = ~scan_end;
    m_d[F_BLINK] = blink_q;
    if (ev_winter) m_d[F_SEASON] = 1'b0;
    if (ev_summer) m_d[F_SEASON] = 1'b1;
    for (int c = 0; c < 4; c++) begin
      if (terr_s[c]) m_d[F_TEMP0 + c] = 1'b1;
    end
    if (ev_ser) m_d[F_SER_RX] = 1'b1;
    if (ev_net) m_d[F_NET_RX] = 1'b1;
    m_d[F_FDIR] = fdir_s;
    if (ev_dn) m_d[F_FB_DN] = 1'b1;
    if (ev_er) m_d[F_FB_ER] = 1'b1;
    if (ev_to) m_d[F_FB_TO] = 1'b1;
  end

  // No reset here: this bank stands for battery-backed storage.
  always_ff @(posedge clk) begin
    m_q <= m_d;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) n_q <= '0;
    else         n_q <= n_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan-boundary images: inputs sampled, outputs and e-mail edge released.

  logic [N_DIN-1:0]  din_mask;
  logic [N_DOUT-1:0] dout_mask;
  logic [N_DIN-1:0]  din_img_q;
  logic [N_KEY-1:0]  key_img_q;
  logic [N_DOUT-1:0] out_coil_q;
  logic [N_NET-1:0]  j_q, j_img_q, k_q;
  logic              email_prev_q;

  assign din_mask  = (cfg_q.in_var == VAR_IN6) ? MASK_IN6 :
                     (cfg_q.in_var == VAR_IN8) ? MASK_IN8 : MASK_IN12;
  assign dout_mask = cfg_q.out8 ? MASK_OUT8 : MASK_OUT4;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      din_img_q    <= '0;
      key_img_q    <= '0;
      out_coil_q   <= '0;
      dout         <= '0;
      analog_sel   <= '0;
      j_q          <= '0;
      j_img_q      <= '0;
      k_q          <= '0;
      net_out      <= '0;
      email_prev_q <= 1'b0;
      email_send   <= 1'b0;
    end else begin
      if (wr_out) out_coil_q <= wdata[N_DOUT-1:0];
      if (net_in_valid) j_q <= net_in;
      if (wr_klo) k_q[31:0] <= wdata;
      if (wr_khi) k_q[N_NET-1:32] <= wdata[N_NET-33:0];
      analog_sel <= {N_ANA{cfg_q.in_var == VAR_IN12}};
      email_send <= scan_end && m_q[F_EMAIL] && !email_prev_q;
      if (scan_end) begin
        din_img_q    <= din_s & din_mask;
        key_img_q    <= cfg_q.keypad ? key_s : '0;
        j_img_q      <= j_q;
        dout         <= out_coil_q & dout_mask;
        net_out      <= k_q;
        email_prev_q <= m_q[F_EMAIL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer and counter status coils.

  logic [15:0]      t_pre_q, c_pre_q, c_last_q;
  logic [N_TMR-1:0] t_stat_q, c_stat_q;
  logic [4:0]       t_idx;
  logic             t_hit;
  cnt_upd_s         cu;

  assign t_idx = wdata[UPD_IDX_LSB +: 5];
  assign t_hit = wdata[15:0] >= t_pre_q;
  assign cu    = cnt_upd_s'(wdata[22:0]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t_pre_q  <= '0;
      c_pre_q  <= '0;
      c_last_q <= '0;
      t_stat_q <= '0;
      c_stat_q <= '0;
    end else begin
      if (wr_tpre) t_pre_q <= wdata[15:0];
      if (wr_cpre) c_pre_q <= wdata[15:0];
      if (wr_tupd && t_idx != 5'h1F) t_stat_q[t_idx] <= t_hit;
      if (wr_cupd && cu.idx != 5'h1F) begin
        if (cu.clr) begin
          c_stat_q[cu.idx] <= 1'b0;
          c_last_q         <= '0;
        end else begin
          c_last_q <= cu.cur;
          if (!cu.down && cu.cur >= c_pre_q) c_stat_q[cu.idx] <= 1'b1;
          if (cu.down && cu.cur == 16'h0000) c_stat_q[cu.idx] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge elements. The previous sample only moves at a scan boundary, so each
  // edge output holds for exactly one scan.

  logic [N_EDGE-1:0] edge_in_q, edge_prev_q, edge_rise, edge_fall;

  assign edge_rise = edge_in_q & ~edge_prev_q;
  assign edge_fall = ~edge_in_q & edge_prev_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_in_q   <= '0;
      edge_prev_q <= '0;
    end else begin
      if (wr_edge) edge_in_q <= wdata;
      if (scan_end) edge_prev_q <= edge_in_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Unmapped and write-only locations read as zero.

  logic [127:0]      m_pad, n_pad;
  logic [DATA_W-1:0] rd_word;

  assign m_pad = {1'b0, m_q};
  assign n_pad = {1'b0, n_q};

  always_comb begin
    rd_word = '0;
    if (addr[5:2] == A_MBANK[5:2]) rd_word = m_pad[addr[1:0]*32 +: 32];
    else if (addr[5:2] == A_NBANK[5:2]) rd_word = n_pad[addr[1:0]*32 +: 32];
    else begin
      unique case (addr)
        A_CFG:     rd_word = {28'h000_0000, cfg_q};
        A_STATUS:  rd_word = {15'h0000, keep_q, scan_cnt_q};
        A_IN_IMG:  rd_word = {12'h000, analog_sel, key_img_q, din_img_q};
        A_OUT:     rd_word = {24'h00_0000, out_coil_q};
        A_T_STAT:  rd_word = {1'b0, t_stat_q};
        A_T_PRE:   rd_word = {16'h0000, t_pre_q};
        A_C_STAT:  rd_word = {1'b0, c_stat_q};
        A_C_PRE:   rd_word = {16'h0000, c_pre_q};
        A_C_LAST:  rd_word = {16'h0000, c_last_q};
        A_J_LO:    rd_word = j_img_q[31:0];
        A_J_HI:    rd_word = {1'b0, j_img_q[N_NET-1:32]};
        A_EDGE_IN: rd_word = edge_in_q;
        A_EDGE_RS: rd_word = edge_rise;
        A_EDGE_FL: rd_word = edge_fall;
        default:   rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)     rdata <= '0;
    else if (rd_en)  rdata <= rd_word;
    else             rdata <= '0;
  end

endmodule : relay_coil_operand_bank
